/* File: logic/camera_gpio.sv */
// Camera general-purpose I/O: output drive, input status, debounce and change events
`default_nettype none
// Operation
// - One general-purpose input and one general-purpose output line are provided.
// - Output line follows the output drive value register: high true, low false.
// - Reading input level state returns high for supply level, low for ground.
// - When armed, each input change raises a network event message to the host; a change while one is still pending merges into it.
// - Input changes shorter than filter length minus one times 480 ns are rejected.
// - Filter length resets to zero; zero disables debouncing completely.
// - Filter length accepts values up to 65535, about 31 ms hold.
module camera_gpio (
  input  wire logic        clk,             // 50 MHz clock
  input  wire logic        rst,             // Async reset, active high
  input  wire logic        aux_input_line,  // Isolated input pin, asynchronous
  output      logic        aux_output_line, // Isolated output pin drive
  input  wire logic        reg_wr,          // Feature register write strobe
  input  wire logic        reg_rd,          // Feature register read strobe
  input  wire logic [2:0]  reg_idx,         // Feature register index
  input  wire logic [31:0] reg_wdata,       // Write data
  output      logic [31:0] reg_rdata,       // Read data, registered
  output      logic        reg_rvalid,      // Read data valid pulse
  output      logic        evt_valid,       // Input-change event pending
  output      logic        evt_level,       // Input level carried by the event
  input  wire logic        evt_ready        // Event accepted by the network sender
);
  // Register file
  logic        out_drive_ff,   nxt_out_drive;
  logic [31:0] evt_route_ff,   nxt_evt_route;
  logic [31:0] evt_choice_ff,  nxt_evt_choice;
  logic [31:0] evt_deliv_ff,   nxt_evt_deliv;
  logic [15:0] filter_len_ff,  nxt_filter_len;
  logic [31:0] rdata_ff,       nxt_rdata;
  logic        rvalid_ff,      nxt_rvalid;
  // Input path
  logic [2:0]  sync_ff;
  logic        stable_ff,      nxt_stable;
  logic        filt_level;
  logic        filt_prev_ff;
  // Step divider
  logic [4:0]  div_ff,         nxt_div;
  logic        step;
  // Event state
  logic        pend_ff,        nxt_pend;
  logic        evt_level_ff,   nxt_evt_level;
  logic        armed;
  logic        in_change;

  // Readback mux used by the registered read path
  function automatic logic [31:0] read_mux(input logic [2:0] idx, input logic drv, input logic lvl,
                                           input logic [31:0] rt, input logic [31:0] ch,
                                           input logic [31:0] dk, input logic [15:0] fl);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (idx)
      gpio_evt_pkg::IDX_OUT_DRIVE:    v[gpio_evt_pkg::OUT_DRIVE_BIT] = drv;
      gpio_evt_pkg::IDX_IN_LEVEL:     v[gpio_evt_pkg::IN_LEVEL_BIT]  = lvl;
      gpio_evt_pkg::IDX_EVT_ROUTE:    v = rt;
      gpio_evt_pkg::IDX_EVT_CHOICE:   v = ch;
      gpio_evt_pkg::IDX_EVT_DELIVERY: v = dk;
      gpio_evt_pkg::IDX_FILTER_LEN:   v = {16'h0000, fl};
      default:                        v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Register writes and registered reads; unmapped indices read as zero
  always_comb begin
    nxt_out_drive  = out_drive_ff;
    nxt_evt_route  = evt_route_ff;
    nxt_evt_choice = evt_choice_ff;
    nxt_evt_deliv  = evt_deliv_ff;
    nxt_filter_len = filter_len_ff;
    nxt_rvalid     = reg_rd;
    nxt_rdata      = rdata_ff;
    if (reg_wr) begin
      unique case (reg_idx)
        gpio_evt_pkg::IDX_OUT_DRIVE:    nxt_out_drive  = reg_wdata[gpio_evt_pkg::OUT_DRIVE_BIT];
        gpio_evt_pkg::IDX_EVT_ROUTE:    nxt_evt_route  = reg_wdata;
        gpio_evt_pkg::IDX_EVT_CHOICE:   nxt_evt_choice = reg_wdata;
        gpio_evt_pkg::IDX_EVT_DELIVERY: nxt_evt_deliv  = reg_wdata;
        gpio_evt_pkg::IDX_FILTER_LEN:   nxt_filter_len = reg_wdata[15:0];
        default:                        nxt_rvalid     = reg_rd;  // Read-only or unmapped: dropped
      endcase
    end
    if (reg_rd) begin
      nxt_rdata = read_mux(reg_idx, out_drive_ff, filt_level, evt_route_ff,
                           evt_choice_ff, evt_deliv_ff, filter_len_ff);
    end
  end

  // Register file flops; filter length comes up as zero, so debouncing starts off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_drive_ff  <= gpio_evt_pkg::OUT_DRIVE_RST;
      evt_route_ff  <= gpio_evt_pkg::EVT_ROUTE_RST;
      evt_choice_ff <= gpio_evt_pkg::EVT_CHOICE_RST;
      evt_deliv_ff  <= gpio_evt_pkg::EVT_DELIVERY_RST;
      filter_len_ff <= gpio_evt_pkg::FILTER_LEN_RST;
      rdata_ff      <= 32'h0000_0000;
      rvalid_ff     <= 1'b0;
    end else begin
      out_drive_ff  <= nxt_out_drive;
      evt_route_ff  <= nxt_evt_route;
      evt_choice_ff <= nxt_evt_choice;
      evt_deliv_ff  <= nxt_evt_deliv;
      filter_len_ff <= nxt_filter_len;
      rdata_ff      <= nxt_rdata;
      rvalid_ff     <= nxt_rvalid;
    end
  end

  // Pin synchroniser: a new level counts only once stages one and two agree
  always_comb begin
    nxt_stable = stable_ff;
    if (sync_ff[1] == sync_ff[2]) begin
      nxt_stable = sync_ff[2];
    end
  end

  // Synchroniser flops; stage zero feeds stage one only, against metastability
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_ff   <= 3'h0;
      stable_ff <= 1'b0;
    end else begin
      sync_ff   <= {sync_ff[1:0], aux_input_line};
      stable_ff <= nxt_stable;
    end
  end

  // Filter step divider: one pulse every 480 ns
  assign step = (div_ff == gpio_evt_pkg::STEP_LAST);
  always_comb begin
    nxt_div = step ? 5'h00 : div_ff + 5'h01;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= 5'h00;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // Debounce filter on the synchronised level
  glitch_filter u_filter (
    .clk   (clk),
    .rst   (rst),
    .step  (step),
    .raw   (stable_ff),
    .len   (filter_len_ff),
    .level (filt_level)
  );

  // Event arming and pending flag; a new change beats an acceptance in the same cycle
  assign armed     = (evt_route_ff  == gpio_evt_pkg::ROUTE_GP_INPUT)
                   && (evt_choice_ff == gpio_evt_pkg::CHOICE_IN_CHANGE)
                   && (evt_deliv_ff  == gpio_evt_pkg::DELIVER_NET_MSG);
  assign in_change = (filt_level != filt_prev_ff);
  always_comb begin
    nxt_pend      = pend_ff;
    nxt_evt_level = evt_level_ff;
    if (pend_ff && evt_ready) begin
      nxt_pend = 1'b0;
    end
    if (in_change && armed) begin
      nxt_pend      = 1'b1;
      nxt_evt_level = filt_level;
    end
  end

  // Event flops; back-to-back changes merge and report the latest level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_prev_ff <= 1'b0;
      pend_ff      <= 1'b0;
      evt_level_ff <= 1'b0;
    end else begin
      filt_prev_ff <= filt_level;
      pend_ff      <= nxt_pend;
      evt_level_ff <= nxt_evt_level;
    end
  end

  assign aux_output_line = out_drive_ff;
  assign reg_rdata       = rdata_ff;
  assign reg_rvalid      = rvalid_ff;
  assign evt_valid       = pend_ff;
  assign evt_level       = evt_level_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  out_drive_a: assert property (reg_wr && reg_idx == gpio_evt_pkg::IDX_OUT_DRIVE
    |=> aux_output_line == $past(reg_wdata[0])) else $error("output line missed write");
  level_read_a: assert property (reg_rd && reg_idx == gpio_evt_pkg::IDX_IN_LEVEL
    |=> reg_rvalid && reg_rdata == {31'h0, $past(filt_level)}) else $error("bad input level read");
  event_raise_a: assert property (in_change && armed
    |=> evt_valid && evt_level == $past(filt_level)) else $error("input change gave no event");
  event_gate_a: assert property (!armed && !evt_valid |=> !evt_valid)
    else $error("event raised while not armed");
  event_hold_a: assert property (evt_valid && !evt_ready |=> evt_valid)
    else $error("event dropped before acceptance");
  filter_step_a: assert property (filter_len_ff != 16'h0000 && $past(filter_len_ff) != 16'h0000
    && filt_level != $past(filt_level) |-> $past(step)) else $error("filter moved off step");
  step_period_a: assert property (step |=> !step [*8] ##1 !step [*8] ##1 !step [*7] ##1 step)
    else $error("step period not 24 cycles");
  filter_bypass_a: assert property (filter_len_ff == 16'h0000 && $past(filter_len_ff) == 16'h0000
    |-> filt_level == $past(stable_ff)) else $error("zero length did not bypass");
  filter_len_a: assert property (reg_wr && reg_idx == gpio_evt_pkg::IDX_FILTER_LEN
    |=> filter_len_ff == $past(reg_wdata[15:0])) else $error("filter length not stored");
  sync_agree_a: assert property ($changed(stable_ff) |-> $past(sync_ff[1]) == $past(sync_ff[2]))
    else $error("input taken before stages agree");

  event_sent_c: cover property (evt_valid && evt_ready);
  filtered_c:   cover property (filter_len_ff != 16'h0000 && $changed(filt_level));
  glitch_c:     cover property (filter_len_ff > 16'h0001 && $changed(stable_ff) ##[1:30] $changed(stable_ff));
  merged_c:     cover property (evt_valid && !evt_ready && in_change && armed);
endmodule
`default_nettype wire

/* File: logic/gpio_evt_pkg.sv */
// Constants shared by the camera I/O block: register indices, resets, enums, timing
`default_nettype none
package gpio_evt_pkg;
  // Register indices on the feature register port
  localparam logic [2:0]  IDX_OUT_DRIVE    = 3'h0;
  localparam logic [2:0]  IDX_IN_LEVEL     = 3'h1;
  localparam logic [2:0]  IDX_EVT_ROUTE    = 3'h2;
  localparam logic [2:0]  IDX_EVT_CHOICE   = 3'h3;
  localparam logic [2:0]  IDX_EVT_DELIVERY = 3'h4;
  localparam logic [2:0]  IDX_FILTER_LEN   = 3'h5;
  // Field positions
  localparam int          OUT_DRIVE_BIT    = 0;
  localparam int          IN_LEVEL_BIT     = 0;
  // Reset values
  localparam logic        OUT_DRIVE_RST    = 1'b0;
  localparam logic [31:0] EVT_ROUTE_RST    = 32'h0000_0000;
  localparam logic [31:0] EVT_CHOICE_RST   = 32'h0000_0000;
  localparam logic [31:0] EVT_DELIVERY_RST = 32'h0000_0000;
  localparam logic [15:0] FILTER_LEN_RST   = 16'h0000;
  // Enumeration values that arm the input-change event
  localparam logic [31:0] ROUTE_GP_INPUT   = 32'h0000_0002;
  localparam logic [31:0] CHOICE_IN_CHANGE = 32'h0000_0005;
  localparam logic [31:0] DELIVER_NET_MSG  = 32'h0000_0003;
  // Filter step timing
  localparam int          CLK_PERIOD_NS    = 20;
  localparam int          FILTER_STEP_NS   = 480;
  localparam int          STEP_CYCLES      = (FILTER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0]  STEP_LAST        = 5'(STEP_CYCLES - 1);
endpackage
`default_nettype wire

/* File: logic/glitch_filter.sv */
// Debounce filter: a change of the input is taken only after it persists for len steps
`default_nettype none
module glitch_filter (
  input  wire logic        clk,      // 50 MHz clock
  input  wire logic        rst,      // Async reset, active high
  input  wire logic        step,     // One-cycle pulse every filter step
  input  wire logic        raw,      // Synchronised input level
  input  wire logic [15:0] len,      // Window length in steps, zero bypasses
  output      logic        level     // Filtered input level
);
  logic        level_ff;
  logic        nxt_level;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;

  // Count steps while the input differs; a return to the old level restarts the window
  always_comb begin
    nxt_level = level_ff;
    nxt_cnt   = cnt_ff;
    if (len == 16'h0000) begin
      nxt_level = raw;
      nxt_cnt   = 16'h0000;
    end else if (raw == level_ff) begin
      nxt_cnt   = 16'h0000;
    end else if (step) begin
      if (cnt_ff + 16'h0001 >= len) begin
        nxt_level = raw;
        nxt_cnt   = 16'h0000;
      end else begin
        nxt_cnt   = cnt_ff + 16'h0001;
      end
    end
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_ff <= 1'b0;
      cnt_ff   <= 16'h0000;
    end else begin
      level_ff <= nxt_level;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign level = level_ff;
endmodule
`default_nettype wire

/* File: testbench/evt_sink.sv */
// Host-side model of the network event receiver, prompt or slow to accept
`default_nettype none
module evt_sink (
  input  wire logic clk,       // 50 MHz clock
  input  wire logic rst,       // Async reset, active high
  input  wire logic slow,      // Accept one cycle in four when high
  input  wire logic evt_valid, // Event pending from the block
  input  wire logic evt_level, // Level carried by the event
  output var  logic evt_ready, // Event accepted
  output var  int   got_cnt,   // Events taken so far
  output var  logic got_level  // Level of the latest event taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_ff;
  // A slow host leaves events pending for a while, so that holding until acceptance is exercised
  always_comb begin
    evt_ready = !slow || (wait_ff == 2'h3);
  end
  // Take each delivered message once; the host does not re-read a stale one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff   <= 2'h0;
      got_cnt   <= 0;
      got_level <= 1'b0;
    end else begin
      wait_ff <= wait_ff + 2'h1;
      if (evt_valid && evt_ready) begin
        got_cnt   <= got_cnt + 1;
        got_level <= evt_level;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/camera_gpio_tb.sv */
// Self-checking bench for the camera I/O block: registers, input path, filter, events
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module camera_gpio_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, aux_input_line, aux_output_line, reg_wr, reg_rd;
  logic [2:0]  reg_idx;
  logic [31:0] reg_wdata, reg_rdata, d, v;
  logic        reg_rvalid, evt_valid, evt_level, evt_ready, slow, got_level, p;
  int          error_cnt, checks, seed, i, n, got_cnt;
  // Clock at 50 MHz
  always #10 clk = ~clk;
  camera_gpio uut (.clk(clk), .rst(rst), .aux_input_line(aux_input_line), .aux_output_line(aux_output_line),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .evt_valid(evt_valid), .evt_level(evt_level), .evt_ready(evt_ready));
  evt_sink host (.clk(clk), .rst(rst), .slow(slow), .evt_valid(evt_valid), .evt_level(evt_level),
    .evt_ready(evt_ready), .got_cnt(got_cnt), .got_level(got_level));
  // Expected read word for a one-bit register
  function automatic logic [31:0] word1(input logic b);
    return {31'h0000_0000, b};
  endfunction
  // Inputs move 1 ns after the edge, so no race with the design's sampling
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] idx, input logic [31:0] dat);
    cyc(1);
    reg_wr = 1'b1; reg_idx = idx; reg_wdata = dat;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] idx, output logic [31:0] dat);
    cyc(1);
    reg_rd = 1'b1; reg_idx = idx;
    cyc(1);
    `CHK("rvalid", 1'b1, reg_rvalid)
    dat = reg_rdata;
    reg_rd = 1'b0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog: the whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial begin
    seed = 29616; clk = 0; rst = 1; aux_input_line = 0; reg_wr = 0; reg_rd = 0;
    reg_idx = 3'h0; reg_wdata = 32'h0000_0000; slow = 0; error_cnt = 0; checks = 0;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    `CHK("out_line", 1'b0, aux_output_line)
    for (i = 0; i < 8; i++) begin
      rd(i[2:0], d);
      `CHK("reset_value", 32'h0000_0000, d)
    end
    $display("reset values done");
    // Random drive values and pin levels with no debounce
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      wr(gpio_evt_pkg::IDX_OUT_DRIVE, v);
      `CHK("out_line", v[0], aux_output_line)
      aux_input_line = v[1];
      cyc(6);
      rd(gpio_evt_pkg::IDX_IN_LEVEL, d);
      `CHK("in_level", word1(v[1]), d)
    end
    $display("drive and level done");
    // Read-only, unmapped and wide writes
    wr(gpio_evt_pkg::IDX_IN_LEVEL, 32'hFFFF_FFFF);
    rd(gpio_evt_pkg::IDX_IN_LEVEL, d);
    `CHK("ro_level", word1(aux_input_line), d)
    wr(3'h6, 32'hFFFF_FFFF);
    rd(3'h6, d);
    `CHK("unmapped", 32'h0000_0000, d)
    wr(gpio_evt_pkg::IDX_FILTER_LEN, 32'hFFFF_FFFF);
    rd(gpio_evt_pkg::IDX_FILTER_LEN, d);
    `CHK("filter_max", 32'h0000_FFFF, d)
    wr(gpio_evt_pkg::IDX_FILTER_LEN, 32'h0000_0000);
    $display("register access done");
    // Arm the input-change event and toggle the pin, host prompt and slow
    wr(gpio_evt_pkg::IDX_EVT_ROUTE, gpio_evt_pkg::ROUTE_GP_INPUT);
    wr(gpio_evt_pkg::IDX_EVT_CHOICE, gpio_evt_pkg::CHOICE_IN_CHANGE);
    wr(gpio_evt_pkg::IDX_EVT_DELIVERY, gpio_evt_pkg::DELIVER_NET_MSG);
    cyc(8);
    for (i = 0; i < 4; i++) begin
      n = got_cnt; slow = i[0];
      aux_input_line = ~aux_input_line;
      cyc(14);
      `CHK("evt_count", n + 1, got_cnt)
      `CHK("evt_level", aux_input_line, got_level)
      `CHK("evt_idle", 1'b0, evt_valid)
    end
    wr(gpio_evt_pkg::IDX_EVT_DELIVERY, 32'h0000_0000);
    n = got_cnt;
    aux_input_line = ~aux_input_line;
    cyc(14);
    `CHK("disarmed", n, got_cnt)
    $display("events done");
    // Filter of two steps: a short glitch is dropped, a held change is taken in its window
    wr(gpio_evt_pkg::IDX_FILTER_LEN, 32'h0000_0002);
    p = aux_input_line;
    aux_input_line = ~p;
    cyc(20);
    aux_input_line = p;
    cyc(60);
    rd(gpio_evt_pkg::IDX_IN_LEVEL, d);
    `CHK("glitch", word1(p), d)
    aux_input_line = ~p;
    cyc(24);
    rd(gpio_evt_pkg::IDX_IN_LEVEL, d);
    `CHK("early", word1(p), d)
    cyc(30);
    rd(gpio_evt_pkg::IDX_IN_LEVEL, d);
    `CHK("held", word1(~p), d)
    $display("filter done");
    results();
  end
endmodule
`default_nettype wire
